// ### design/reader_station.sv
// How it works
// - stop out only if stop switch and on-line
// - master withholds automatic step pulses while stopped
// - advance edge sets flip-flop only when stopped
// - flip-flop sent as step-read, master steps one
// - stop released, master resumes automatic stepping
// - every switch debounced by set-reset latch
// - manual steps blocked when running on-line
// - manual steps merged onto driver step line
// - stop, on-line and step give alarm suppress
// - stop and step-read held off for 80 ms
// - separate verify and feed alarm flags
// - alarm flags set only while on-line
// - set flag lights lamp and raises alarm
// - alarm out held low at power-on
// - master treats any alarm as blocking all
// - alarm reset switch clears both flags
// - on-line lamp follows on-line signal
// - alarm out gets same power-up gating
// - stop lamp lit in stop position
`timescale 1ns/10ps
module reader_station #(
  parameter int unsigned POWERUP_CYCLES = reader_pkg::POWERUP_CYC
) (
  input  wire logic                        I_CLK,
  input  wire logic                        I_RSTN,
  input  wire logic [reader_pkg::SW_N-1:0] I_SW_MAKE,
  input  wire logic [reader_pkg::SW_N-1:0] I_SW_BREAK,
  input  wire logic                        I_VERIFY_ERR,
  input  wire logic                        I_FEED_ERR,
  reader_link_if.station                   LINK,
  output logic                             O_DRIVER_STEP,
  output logic                             O_STOP_LAMP,
  output logic                             O_ONLINE_LAMP,
  output logic                             O_VERIFY_LAMP,
  output logic                             O_FEED_LAMP
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [reader_pkg::SW_N-1:0]  mk_s1_r;
  logic [reader_pkg::SW_N-1:0]  mk_s2_r;
  logic [reader_pkg::SW_N-1:0]  bk_s1_r;
  logic [reader_pkg::SW_N-1:0]  bk_s2_r;
  logic [2:0]                   in_s1_r;
  logic [2:0]                   in_s2_r;
  logic [reader_pkg::SW_N-1:0]  deb_r;
  logic [reader_pkg::SW_N-1:0]  deb_nxt;
  logic [reader_pkg::SW_N-1:0]  deb_d_r;
  logic [reader_pkg::SW_N-1:0]  rise;
  logic [reader_pkg::PWR_W-1:0] pwr_cnt_r;
  logic [reader_pkg::PWR_W-1:0] pwr_cnt_nxt;
  logic                         gate_r;
  logic                         gate_nxt;
  logic                         online;
  logic                         stop_act;
  logic                         man_pass;
  logic                         adv_r;
  logic                         adv_nxt;
  logic                         verr_r;
  logic                         verr_nxt;
  logic                         ferr_r;
  logic                         ferr_nxt;
  logic                         stop_out_r;
  logic                         stop_out_nxt;
  logic                         step_read_r;
  logic                         step_read_nxt;
  logic                         supp_r;
  logic                         supp_nxt;
  logic                         alarm_r;
  logic                         alarm_nxt;
  logic                         drv_r;
  logic                         drv_nxt;
  logic                         stop_lamp_r;
  logic                         online_lamp_r;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------

  // two stages on the switch, error and on-line inputs; stage one feeds stage two only
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      mk_s1_r <= '0;
      mk_s2_r <= '0;
      bk_s1_r <= '0;
      bk_s2_r <= '0;
      in_s1_r <= 3'h0;
      in_s2_r <= 3'h0;
    end else begin
      mk_s1_r <= I_SW_MAKE;
      mk_s2_r <= mk_s1_r;
      bk_s1_r <= I_SW_BREAK;
      bk_s2_r <= bk_s1_r;
      in_s1_r <= {I_FEED_ERR, I_VERIFY_ERR, LINK.on_line};
      in_s2_r <= in_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // debounce latches and edge events
  // ----------------------------------------------------------------

  // make contact sets, break contact clears; bounce on one contact
  // alone never moves the latch, so one clean change per throw
  always_comb begin
    for (int i = 0; i < reader_pkg::SW_N; i++) begin
      if (mk_s2_r[i]) begin
        deb_nxt[i] = 1'b1;
      end else if (bk_s2_r[i]) begin
        deb_nxt[i] = 1'b0;
      end else begin
        deb_nxt[i] = deb_r[i];
      end
    end
  end

  // single-cycle rising events of the debounced levels
  assign rise = deb_r & ~deb_d_r;

  // shared qualifiers
  assign online   = in_s2_r[0];
  assign stop_act = deb_r[reader_pkg::SW_STOP] & online;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      deb_r   <= '0;
      deb_d_r <= '0;
    end else begin
      deb_r   <= deb_nxt;
      deb_d_r <= deb_r;
    end
  end

  // ----------------------------------------------------------------
  // power-up output gating
  // ----------------------------------------------------------------

  // counter freezes once the gate opens, so it never wraps back shut
  always_comb begin
    pwr_cnt_nxt = pwr_cnt_r;
    gate_nxt    = gate_r;
    if (!gate_r) begin
      pwr_cnt_nxt = pwr_cnt_r + 1'b1;
      if (pwr_cnt_r == reader_pkg::PWR_W'(POWERUP_CYCLES - 1)) begin
        gate_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      pwr_cnt_r <= '0;
      gate_r    <= 1'b0;
    end else begin
      pwr_cnt_r <= pwr_cnt_nxt;
      gate_r    <= gate_nxt;
    end
  end

  // ----------------------------------------------------------------
  // stop, single advance and manual step
  // ----------------------------------------------------------------

  // manual steps pass unless the reader is running on incoming pulses
  assign man_pass = deb_r[reader_pkg::SW_STOP] | ~online;

  always_comb begin
    // advance is taken only while stopped; it lives one cycle
    if (rise[reader_pkg::SW_ADV] && stop_act) begin
      adv_nxt = 1'b1;
    end else if (adv_r || !stop_act) begin
      adv_nxt = 1'b0;
    end else begin
      adv_nxt = adv_r;
    end
    stop_out_nxt  = gate_r & stop_act;
    step_read_nxt = gate_r & adv_r & stop_act;
    // master steps share the driver line with passed manual steps;
    // two pulses in adjacent cycles merge into one longer pulse
    drv_nxt       = (rise[reader_pkg::SW_STEP] & man_pass)
                    | LINK.step_pulse;
    supp_nxt      = stop_act & deb_r[reader_pkg::SW_STEP];
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      adv_r       <= 1'b0;
      stop_out_r  <= 1'b0;
      step_read_r <= 1'b0;
      drv_r       <= 1'b0;
      supp_r      <= 1'b0;
    end else begin
      adv_r       <= adv_nxt;
      stop_out_r  <= stop_out_nxt;
      step_read_r <= step_read_nxt;
      drv_r       <= drv_nxt;
      supp_r      <= supp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------

  // an error arriving with the reset press wins, so none is lost
  always_comb begin
    if (in_s2_r[1] && online) begin
      verr_nxt = 1'b1;
    end else if (rise[reader_pkg::SW_ARST]) begin
      verr_nxt = 1'b0;
    end else begin
      verr_nxt = verr_r;
    end
    if (in_s2_r[2] && online) begin
      ferr_nxt = 1'b1;
    end else if (rise[reader_pkg::SW_ARST]) begin
      ferr_nxt = 1'b0;
    end else begin
      ferr_nxt = ferr_r;
    end
    // held low until the gate opens so a stale flag cannot stall
    // every other sender on the line
    alarm_nxt = gate_r & (verr_r | ferr_r);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      verr_r  <= 1'b0;
      ferr_r  <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      verr_r  <= verr_nxt;
      ferr_r  <= ferr_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // lamps
  // ----------------------------------------------------------------

  // lamps are local only, so they skip the power-up gate
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      stop_lamp_r   <= 1'b0;
      online_lamp_r <= 1'b0;
    end else begin
      stop_lamp_r   <= deb_r[reader_pkg::SW_STOP];
      online_lamp_r <= online;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign LINK.reader_stop    = stop_out_r;
  assign LINK.step_read      = step_read_r;
  assign LINK.alarm_suppress = supp_r;
  assign LINK.alarm          = alarm_r;
  assign O_DRIVER_STEP       = drv_r;
  assign O_STOP_LAMP         = stop_lamp_r;
  assign O_ONLINE_LAMP       = online_lamp_r;
  assign O_VERIFY_LAMP       = verr_r;
  assign O_FEED_LAMP         = ferr_r;

endmodule

// ### design/reader_pkg.sv
package reader_pkg;
  // ----------------------------------------------------------------
  // clock and power-up timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned POWERUP_MS  = 80;
  localparam int unsigned POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
  localparam int          PWR_W       = 25;

  // ----------------------------------------------------------------
  // operator switch indices
  // ----------------------------------------------------------------
  localparam int SW_STOP = 0;
  localparam int SW_ADV  = 1;
  localparam int SW_STEP = 2;
  localparam int SW_ARST = 3;
  localparam int SW_N    = 4;

  // ----------------------------------------------------------------
  // controller registers (avalon byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_DIV     = 4'h4;
  localparam logic [3:0]  REG_STAT    = 4'h8;
  localparam int          CTRL_ONLINE = 0;
  localparam int          CTRL_RUN    = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h0;
  localparam int          DIV_W       = 16;
  localparam logic [15:0] DIV_RST     = 16'h0100;
  localparam int          STAT_STOP   = 0;
  localparam int          STAT_ALARM  = 1;
  localparam int          STAT_SUPP   = 2;
  localparam int          STAT_ADV    = 3;
endpackage

// ### design/reader_link_if.sv
`timescale 1ns/10ps
interface reader_link_if;
  logic reader_stop;
  logic step_read;
  logic alarm_suppress;
  logic alarm;
  logic on_line;
  logic step_pulse;

  modport station (
    output reader_stop,
    output step_read,
    output alarm_suppress,
    output alarm,
    input  on_line,
    input  step_pulse
  );

  modport master (
    input  reader_stop,
    input  step_read,
    input  alarm_suppress,
    input  alarm,
    output on_line,
    output step_pulse
  );
endinterface

// ### design/master_seq.sv
`timescale 1ns/10ps
module master_seq (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RSTN,
  reader_link_if.master                      LINK,
  input  wire logic [reader_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                          I_AVS_READ,
  input  wire logic                          I_AVS_WRITE,
  input  wire logic [31:0]                   I_AVS_WRITEDATA,
  output logic      [31:0]                   O_AVS_READDATA,
  output logic                               O_AVS_WAITREQUEST
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                         wait_r;
  logic                         wait_nxt;
  logic [31:0]                  rdata_r;
  logic [31:0]                  rdata_nxt;
  logic [1:0]                   ctrl_r;
  logic [1:0]                   ctrl_nxt;
  logic [reader_pkg::DIV_W-1:0] div_r;
  logic [reader_pkg::DIV_W-1:0] div_nxt;
  logic [reader_pkg::DIV_W-1:0] cnt_r;
  logic [reader_pkg::DIV_W-1:0] cnt_nxt;
  logic                         supp_seen_r;
  logic                         supp_seen_nxt;
  logic                         adv_seen_r;
  logic                         adv_seen_nxt;
  logic                         online_r;
  logic                         step_r;
  logic                         step_nxt;
  logic                         accept;
  logic                         stat_clr;
  logic                         tick;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign accept   = (I_AVS_READ | I_AVS_WRITE) & ~wait_r;
  assign stat_clr = accept & I_AVS_WRITE & (I_AVS_ADDRESS == reader_pkg::REG_STAT);

  always_comb begin
    wait_nxt  = ~((I_AVS_READ | I_AVS_WRITE) & wait_r);
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    div_nxt   = div_r;
    if (I_AVS_READ && wait_r) begin
      case (I_AVS_ADDRESS)
        reader_pkg::REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
        reader_pkg::REG_DIV:  rdata_nxt = {16'h0, div_r};
        reader_pkg::REG_STAT: rdata_nxt = {28'h0, adv_seen_r, supp_seen_r,
                                           LINK.alarm, LINK.reader_stop};
        default:              rdata_nxt = 32'h0;
      endcase
    end
    if (accept && I_AVS_WRITE) begin
      case (I_AVS_ADDRESS)
        reader_pkg::REG_CTRL: ctrl_nxt = I_AVS_WRITEDATA[1:0];
        reader_pkg::REG_DIV:  div_nxt  = I_AVS_WRITEDATA[15:0];
        default:              ctrl_nxt = ctrl_r;
      endcase
    end
    // sticky seen bits; a new event beats a write-one clear
    supp_seen_nxt = LINK.alarm_suppress
                    | (supp_seen_r & ~(stat_clr & I_AVS_WRITEDATA[reader_pkg::STAT_SUPP]));
    adv_seen_nxt  = LINK.step_read
                    | (adv_seen_r & ~(stat_clr & I_AVS_WRITEDATA[reader_pkg::STAT_ADV]));
  end

  // ----------------------------------------------------------------
  // step pulse source
  // ----------------------------------------------------------------
  assign tick = (cnt_r == '0);

  // stop withholds automatic steps and any alarm withholds all; step-read gives one;
  // gated by the driven on-line level, so no step leads it at turn-on
  always_comb begin
    cnt_nxt  = tick ? div_r : cnt_r - 1'b1;
    step_nxt = online_r & ~LINK.alarm
               & ((tick & ctrl_r[reader_pkg::CTRL_RUN] & ~LINK.reader_stop)
                  | (LINK.step_read & LINK.reader_stop));
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      wait_r      <= 1'b1;
      rdata_r     <= 32'h0;
      ctrl_r      <= reader_pkg::CTRL_RST;
      div_r       <= reader_pkg::DIV_RST;
      cnt_r       <= reader_pkg::DIV_RST;
      supp_seen_r <= 1'b0;
      adv_seen_r  <= 1'b0;
      online_r    <= 1'b0;
      step_r      <= 1'b0;
    end else begin
      wait_r      <= wait_nxt;
      rdata_r     <= rdata_nxt;
      ctrl_r      <= ctrl_nxt;
      div_r       <= div_nxt;
      cnt_r       <= cnt_nxt;
      supp_seen_r <= supp_seen_nxt;
      adv_seen_r  <= adv_seen_nxt;
      online_r    <= ctrl_r[reader_pkg::CTRL_ONLINE];
      step_r      <= step_nxt;
    end
  end

  assign LINK.on_line      = online_r;
  assign LINK.step_pulse   = step_r;
  assign O_AVS_READDATA    = rdata_r;
  assign O_AVS_WAITREQUEST = wait_r;

endmodule

// ### sim/reader_link_checker.sv
`timescale 1ns/10ps
module reader_link_checker #(
  parameter int unsigned POWERUP_CYCLES = 20
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic reader_stop,
  input wire logic step_read,
  input wire logic alarm_suppress,
  input wire logic alarm,
  input wire logic on_line,
  input wire logic step_pulse
);
  // ----------------------------------------------------------------
  // cycles since reset release
  // ----------------------------------------------------------------
  int unsigned up_cnt_r;
  int unsigned up_cnt_nxt;

  // saturates so a long run never wraps back into the gated span
  always_comb begin
    up_cnt_nxt = (up_cnt_r > POWERUP_CYCLES) ? up_cnt_r : up_cnt_r + 1;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      up_cnt_r <= 0;
    end else begin
      up_cnt_r <= up_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence adv_req;
    step_read && reader_stop && on_line && !alarm;
  endsequence

  sequence halted;
    reader_stop && !step_read;
  endsequence

  power_gate_a: assert property (
    up_cnt_r < POWERUP_CYCLES |-> !reader_stop && !step_read && !alarm)
    else $error("link output active inside power-up span");
  read_pulse_a: assert property (step_read |=> !step_read)
    else $error("step_read longer than one cycle");
  read_stopped_a: assert property (
    step_read |-> reader_stop || $past(reader_stop))
    else $error("step_read without reader stop");
  one_step_a: assert property (adv_req |=> step_pulse)
    else $error("no step pulse after step_read");
  halt_a: assert property (halted |=> !step_pulse)
    else $error("step pulse while stopped");
  alarm_block_a: assert property (alarm && !step_read |=> !step_pulse)
    else $error("step pulse during alarm");
  offline_a: assert property (!on_line [*2] |=> !step_pulse)
    else $error("step pulse while off line");
  stop_online_a: assert property (!on_line [*4] |-> !reader_stop)
    else $error("reader stop while off line");
  supp_online_a: assert property (!on_line [*4] |-> !alarm_suppress)
    else $error("alarm suppress while off line");
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int unsigned PWR = 20;
  logic                        clk;
  logic                        rst_n;
  logic [reader_pkg::SW_N-1:0] sw_make;
  logic [reader_pkg::SW_N-1:0] sw_break;
  logic                        verr, ferr, drv_step, drv_q;
  logic                        stop_lamp, online_lamp, verify_lamp, feed_lamp;
  logic [3:0]                  av_addr;
  logic                        av_rd, av_wr, av_wait;
  logic [31:0]                 av_wdata, av_rdata, seed, r;
  int                          err_count, compares, sr_cnt, drv_cnt;
  reader_link_if link ();

  reader_station #(.POWERUP_CYCLES(PWR)) reader_station_inst (
    .I_CLK(clk), .I_RSTN(rst_n), .I_SW_MAKE(sw_make), .I_SW_BREAK(sw_break),
    .I_VERIFY_ERR(verr), .I_FEED_ERR(ferr), .LINK(link.station),
    .O_DRIVER_STEP(drv_step), .O_STOP_LAMP(stop_lamp), .O_ONLINE_LAMP(online_lamp),
    .O_VERIFY_LAMP(verify_lamp), .O_FEED_LAMP(feed_lamp));
  master_seq master_seq_inst (
    .I_CLK(clk), .I_RSTN(rst_n), .LINK(link.master), .I_AVS_ADDRESS(av_addr),
    .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wdata),
    .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait));
  reader_link_checker #(.POWERUP_CYCLES(PWR)) reader_link_checker_inst (
    .I_CLK(clk), .I_RSTN(rst_n), .reader_stop(link.reader_stop),
    .step_read(link.step_read), .alarm_suppress(link.alarm_suppress),
    .alarm(link.alarm), .on_line(link.on_line), .step_pulse(link.step_pulse));

  always #2 clk = ~clk;

  // pulse counters sample at the falling edge, where outputs have settled
  always @(negedge clk) begin
    if (link.step_read === 1'b1) sr_cnt++;
    if (drv_step === 1'b1 && drv_q !== 1'b1) drv_cnt++;
    drv_q = drv_step;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request held until the rising edge that samples waitrequest low;
  // data taken and request dropped at that edge, the watchdog ends a hang
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk);
    av_addr  <= a;
    av_wdata <= d;
    av_wr    <= wr;
    av_rd    <= !wr;
    do begin
      @(posedge clk);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av_xfer(1'b0, a, 32'h0, q);
    chk_word(what, exp, q);
  endtask

  // a bouncing make contact leaves the break contact open throughout
  task automatic press(input int idx, input bit bounce);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      r = rnd();
      sw_make[idx]  <= bounce ? r[0] : 1'b1;
      sw_break[idx] <= 1'b0;
    end
    @(posedge clk);
    sw_make[idx] <= 1'b1;
    cyc(10);
  endtask

  task automatic release_sw(input int idx);
    @(posedge clk);
    sw_make[idx]  <= 1'b0;
    sw_break[idx] <= 1'b1;
    cyc(10);
  endtask

  task automatic err_pulse(input int i);
    @(posedge clk);
    verr <= (i == 0);
    ferr <= (i == 1);
    cyc(6);
    verr <= 1'b0;
    ferr <= 1'b0;
    cyc(4);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    seed = 32'h9a9f31d1;
    {clk, rst_n, verr, ferr, av_rd, av_wr, drv_q} = '0;
    {sw_make, av_addr, av_wdata, err_count, compares, sr_cnt, drv_cnt} = '0;
    sw_break = '1;
    cyc(3);
    rst_n <= 1'b1;
    cyc(30);
    rd_chk("ctrl_rst", reader_pkg::REG_CTRL, 32'h0);
    rd_chk("div_rst", reader_pkg::REG_DIV, {16'h0, reader_pkg::DIV_RST});
    rd_chk("stat_rst", reader_pkg::REG_STAT, 32'h0);
    r = rnd();
    av_write(4'hc, r);
    rd_chk("unmapped", 4'hc, 32'h0);
    av_write(reader_pkg::REG_DIV, r);
    rd_chk("div_rw", reader_pkg::REG_DIV, {16'h0, r[15:0]});
    $display("test regs done");
    av_write(reader_pkg::REG_DIV, 32'h3);
    av_write(reader_pkg::REG_CTRL, 32'h3);
    // the step counter drains its reset period before the new divisor loads
    cyc(270);
    drv_cnt = 0;
    cyc(40);
    chk_bit("auto_rate", 1'b1, drv_cnt inside {[9:11]});
    chk_bit("online_lamp", 1'b1, online_lamp);
    sr_cnt = 0;
    press(reader_pkg::SW_ADV, 1'b0);
    release_sw(reader_pkg::SW_ADV);
    chk_word("adv_running", 32'h0, 32'(sr_cnt));
    av_write(reader_pkg::REG_CTRL, 32'h1);
    cyc(5);
    drv_cnt = 0;
    press(reader_pkg::SW_STEP, 1'b0);
    release_sw(reader_pkg::SW_STEP);
    chk_word("step_blocked", 32'h0, 32'(drv_cnt));
    $display("test running done");
    av_write(reader_pkg::REG_CTRL, 32'h3);
    press(reader_pkg::SW_STOP, 1'b0);
    chk_bit("stop_lamp", 1'b1, stop_lamp);
    chk_bit("reader_stop", 1'b1, link.reader_stop);
    chk_bit("no_suppress", 1'b0, link.alarm_suppress);
    drv_cnt = 0;
    cyc(30);
    chk_word("stopped_steps", 32'h0, 32'(drv_cnt));
    for (int k = 0; k < 2; k++) begin
      {sr_cnt, drv_cnt} = '0;
      press(reader_pkg::SW_ADV, k == 1);
      release_sw(reader_pkg::SW_ADV);
      chk_word("adv_reads", 32'h1, 32'(sr_cnt));
      chk_word("adv_steps", 32'h1, 32'(drv_cnt));
    end
    rd_chk("stat_adv", reader_pkg::REG_STAT, 32'h9);
    av_write(reader_pkg::REG_STAT, 32'h8);
    rd_chk("stat_clr", reader_pkg::REG_STAT, 32'h1);
    drv_cnt = 0;
    press(reader_pkg::SW_STEP, 1'b0);
    chk_bit("suppress", 1'b1, link.alarm_suppress);
    release_sw(reader_pkg::SW_STEP);
    chk_word("manual_steps", 32'h1, 32'(drv_cnt));
    rd_chk("stat_supp", reader_pkg::REG_STAT, 32'h5);
    release_sw(reader_pkg::SW_STOP);
    chk_bit("stop_off", 1'b0, link.reader_stop);
    chk_bit("stop_lamp_off", 1'b0, stop_lamp);
    drv_cnt = 0;
    cyc(40);
    chk_bit("resumed", 1'b1, drv_cnt inside {[9:11]});
    $display("test stop done");
    for (int i = 0; i < 2; i++) begin
      av_write(reader_pkg::REG_CTRL, 32'h2);
      cyc(5);
      chk_bit("online_lamp_off", 1'b0, online_lamp);
      err_pulse(i);
      chk_bit("flag_offline", 1'b0, verify_lamp | feed_lamp);
      av_write(reader_pkg::REG_CTRL, 32'h3);
      cyc(5);
      err_pulse(i);
      chk_bit("verify_lamp", i == 0, verify_lamp);
      chk_bit("feed_lamp", i == 1, feed_lamp);
      chk_bit("alarm_out", 1'b1, link.alarm);
      drv_cnt = 0;
      cyc(30);
      chk_word("alarm_halt", 32'h0, 32'(drv_cnt));
      press(reader_pkg::SW_ARST, 1'b1);
      release_sw(reader_pkg::SW_ARST);
      chk_bit("lamps_off", 1'b0, verify_lamp | feed_lamp);
      chk_bit("alarm_off", 1'b0, link.alarm);
    end
    $display("test alarm done");
    // second reset with stop held and an error standing: link gated through the power-up span, then open
    @(posedge clk);
    rst_n                         <= 1'b0;
    sw_make[reader_pkg::SW_STOP]  <= 1'b1;
    sw_break[reader_pkg::SW_STOP] <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    av_write(reader_pkg::REG_CTRL, 32'h1);
    verr <= 1'b1;
    cyc(10);
    chk_bit("gated_stop", 1'b0, link.reader_stop);
    chk_bit("gated_alarm", 1'b0, link.alarm);
    chk_bit("early_lamp", 1'b1, verify_lamp);
    cyc(10);
    chk_bit("open_stop", 1'b1, link.reader_stop);
    chk_bit("open_alarm", 1'b1, link.alarm);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
